// [crb_pkg.sv]
// constants, types and helpers shared by the command interpreter files
`default_nettype none
package crb_pkg;
    // ------------------------------------------------------------
    // framing bytes
    // ------------------------------------------------------------
    localparam logic [7:0] HDR_WORD = 8'hAA;
    localparam logic [7:0] HDR_BAUD = 8'h00;
    localparam logic [7:0] CMD_CONT = 8'h0D;
    localparam logic [7:0] CMD_BAUD = 8'h0A;
    localparam logic [7:0] TERM_WORD = 8'hFF;
    localparam logic [7:0] HDR_CMP = 8'h02;
    localparam logic [7:0] TERM_CMP = 8'h03;
    localparam logic [7:0] PAD_WORD = 8'h00;
    localparam logic [15:0] ACK_SIZE = 16'h0001;
    // ------------------------------------------------------------
    // rate codes
    // ------------------------------------------------------------
    localparam logic [15:0] RATE_1200 = 16'h000C;
    localparam logic [15:0] RATE_4800 = 16'h0030;
    localparam logic [15:0] RATE_9600 = 16'h0060;
    localparam logic [15:0] RATE_19200 = 16'h00C0;
    localparam logic [15:0] RATE_38400 = 16'h0180;
    localparam logic [15:0] RATE_57600 = 16'h0240;
    localparam logic [15:0] RATE_115200 = 16'h0480;
    localparam logic [15:0] RATE_RESET = RATE_9600;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned DUP_UNIT_S = 1;
    localparam int unsigned SEC_CYCLES = DUP_UNIT_S * CLK_HZ;
    localparam logic [15:0] DELAY_MAX_S = 16'h003C;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_CFG = 12'h008;
    localparam logic [11:0] OFF_DELAY = 12'h00C;
    localparam logic [11:0] OFF_CKSUM = 12'h010;
    localparam int CTRL_COMPACT_BIT = 0;
    localparam int CTRL_CKSUM_BIT = 1;
    localparam int STAT_CONT_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_RATE_LSB = 16;
    localparam logic [1:0] CTRL_RESET = 2'b00;
    localparam logic [7:0] CKSUM_RESET = 8'h00;

    typedef enum logic [1:0] {K_ACK_CONT = 2'b00, K_ACK_BAUD = 2'b01, K_DATA = 2'b10} crb_kind_e;
    typedef enum logic [1:0] {ST_RX = 2'b00, ST_SEND = 2'b01} crb_state_e;

    // cycles per bit for a rate code, zero for an unknown code
    function automatic logic [15:0] rate_div(input logic [15:0] code);
        logic [15:0] d;
        d = 16'h0000;
        case (code)
            RATE_1200: d = 16'(CLK_HZ / 1200);
            RATE_4800: d = 16'(CLK_HZ / 4800);
            RATE_9600: d = 16'(CLK_HZ / 9600);
            RATE_19200: d = 16'(CLK_HZ / 19200);
            RATE_38400: d = 16'(CLK_HZ / 38400);
            RATE_57600: d = 16'(CLK_HZ / 57600);
            RATE_115200: d = 16'(CLK_HZ / 115200);
            default: d = 16'h0000;
        endcase
        return d;
    endfunction : rate_div
endpackage : crb_pkg
`default_nettype wire

// [crb_baud_if.sv]
// bit-rate divisor and tick between interpreter and rate generator
`default_nettype none
interface crb_baud_if;
    logic [15:0] div;
    logic tick;
    modport ctl (output div, input tick);
    modport gen (input div, output tick);
endinterface : crb_baud_if
`default_nettype wire

// [crb_baud_gen.sv]
// bit-rate enable divider
`default_nettype none
module crb_baud_gen
    import crb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    crb_baud_if.gen bif
);
    logic [15:0] cnt_q;
    logic [15:0] div_q;
    logic tick_q;

    // restart on a divisor change so the first bit at a new rate is full length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 16'h0000;
            div_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q <= bif.div;
            tick_q <= 1'b0;
            if (bif.div != div_q || cnt_q + 16'h0001 >= bif.div)
            begin
                cnt_q <= 16'h0000;
                tick_q <= (bif.div == div_q);
            end
            else
            begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    assign bif.tick = tick_q;
endmodule : crb_baud_gen
`default_nettype wire

// [crb_cmd.sv]
// continuous-read and baud-rate command interpreter with apb registers
//
// The address map and register access over APB were left to the implementer.
`default_nettype none
// Operation
// - compact request: header, size, 0D, fields, terminator
// - compact ack: header, size one, echo, checksum
// - word request: AA 0D, three words, FF FF
// - ack first, then data per tag entry
// - word data: echo, 00-padded bytes, FF FF
// - read length zero stops continuous reading
// - word stop answer: echo and terminator only
// - delay counts whole seconds of tag absence
// - read length bytes from start address
// - serial rate resets to 9600
// - accepted rate change switches the port
// - decode seven rate codes
// - baud request: 00 0A, code, FF FF
// - nonzero length enters, zero leaves
// - delay 0..60, zero repeats without suppression
// - other commands run, continuous reading resumes
module crb_cmd
    import crb_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic baud_tick,
    output logic [15:0] baud_div,
    input wire logic tag_present,
    output logic tag_rd_start,
    output logic [15:0] tag_rd_addr,
    output logic [15:0] tag_rd_len,
    input wire logic tag_rd_valid,
    input wire logic [7:0] tag_rd_data,
    output logic tag_rd_ready,
    output logic cont_active
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    crb_baud_if bif ();
    crb_state_e state_q;
    crb_kind_e kind_q;
    logic [1:0] ctrl_q;
    logic [7:0] cksum_q;
    logic [31:0] prdata_q;
    logic [3:0] idx_q;
    logic is_baud_q;
    logic [47:0] sh_q;
    logic exec_q;
    logic cont_q;
    logic armed_q;
    logic [15:0] addr_q;
    logic [15:0] len_q;
    logic [15:0] dly_q;
    logic [15:0] rate_q;
    logic [17:0] seq_q;
    logic tx_valid_q;
    logic [7:0] tx_data_q;
    logic start_q;
    logic [31:0] sec_cnt_q;
    logic [15:0] abs_s_q;
    logic compact;
    logic rx_take;
    logic [15:0] f_addr;
    logic [15:0] f_len;
    logic [15:0] f_dly;
    logic [3:0] body_end;
    logic acc_cont;
    logic acc_baud;
    logic go_read;
    logic [7:0] nb;
    logic nb_last;
    logic nb_tag;
    logic load;
    logic last_fire;
    logic [17:0] n2;

    assign compact = ctrl_q[CTRL_COMPACT_BIT];
    assign rx_ready = (state_q == ST_RX) && !exec_q;
    assign rx_take = rx_valid && rx_ready;
    assign body_end = is_baud_q ? 4'd4 : 4'd8;

    // ------------------------------------------------------------
    // request parser
    // ------------------------------------------------------------
    // a bad byte drops the frame; the host resends after its own timeout
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idx_q <= 4'd0;
            is_baud_q <= 1'b0;
            sh_q <= 48'h0000_0000_0000;
            exec_q <= 1'b0;
        end
        else
        begin
            exec_q <= 1'b0;
            if (rx_take && compact)
            begin
                if (idx_q < 4'd2)
                    idx_q <= (rx_data == HDR_CMP) ? idx_q + 4'd1 : 4'd0;
                else if (idx_q < 4'd4)
                    idx_q <= idx_q + 4'd1;
                else if (idx_q == 4'd4)
                begin
                    idx_q <= (rx_data == CMD_CONT) ? 4'd5 : 4'd0;
                    is_baud_q <= 1'b0;
                end
                else if (idx_q < 4'd10)
                begin
                    sh_q <= {sh_q[39:0], rx_data};
                    idx_q <= idx_q + 4'd1;
                end
                else if (idx_q == 4'd10 && ctrl_q[CTRL_CKSUM_BIT])
                    idx_q <= 4'd11;
                else
                begin
                    idx_q <= 4'd0;
                    exec_q <= (rx_data == TERM_CMP);
                end
            end
            else if (rx_take)
            begin
                if (idx_q == 4'd0)
                begin
                    idx_q <= (rx_data == HDR_WORD || rx_data == HDR_BAUD) ? 4'd1 : 4'd0;
                    is_baud_q <= (rx_data == HDR_BAUD);
                end
                else if (idx_q == 4'd1)
                    idx_q <= (rx_data == (is_baud_q ? CMD_BAUD : CMD_CONT)) ? 4'd2 : 4'd0;
                else if (idx_q < body_end)
                begin
                    sh_q <= {sh_q[39:0], rx_data};
                    idx_q <= idx_q + 4'd1;
                end
                else if (idx_q == body_end)
                    idx_q <= (rx_data == TERM_WORD) ? idx_q + 4'd1 : 4'd0;
                else
                begin
                    idx_q <= 4'd0;
                    exec_q <= (rx_data == TERM_WORD);
                end
            end
        end
    end

    // fields, most significant byte first
    assign f_addr = compact ? sh_q[39:24] : sh_q[47:32];
    assign f_len = compact ? sh_q[23:8] : sh_q[31:16];
    assign f_dly = compact ? {8'h00, sh_q[7:0]} : sh_q[15:0];
    assign acc_baud = exec_q && is_baud_q && (rate_div(sh_q[15:0]) != 16'h0000);
    assign acc_cont = exec_q && !is_baud_q && (f_dly <= DELAY_MAX_S);
    assign go_read = (state_q == ST_RX) && !exec_q && cont_q && armed_q && tag_present;

    // ------------------------------------------------------------
    // continuous-read mode and duplicate suppression
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cont_q <= 1'b0;
            addr_q <= 16'h0000;
            len_q <= 16'h0000;
            dly_q <= 16'h0000;
        end
        else if (acc_cont)
        begin
            cont_q <= (f_len != 16'h0000);
            addr_q <= f_addr;
            len_q <= f_len;
            dly_q <= f_dly;
        end
    end

    // absence time in whole seconds, saturating above the largest delay
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_cnt_q <= 32'h0000_0000;
            abs_s_q <= 16'h0000;
        end
        else if (tag_present)
        begin
            sec_cnt_q <= 32'h0000_0000;
            abs_s_q <= 16'h0000;
        end
        else if (sec_cnt_q + 32'h0000_0001 >= 32'(SEC_CYC))
        begin
            sec_cnt_q <= 32'h0000_0000;
            if (abs_s_q <= DELAY_MAX_S)
                abs_s_q <= abs_s_q + 16'h0001;
        end
        else
            sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end

    // delay zero re-arms at once, so a resting tag is reported again and again
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_q <= 1'b0;
        else if (acc_cont)
            armed_q <= 1'b1;
        else if (go_read)
            armed_q <= 1'b0;
        else if (cont_q && (dly_q == 16'h0000 || (!tag_present && abs_s_q >= dly_q)))
            armed_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // commands are served between tag reports; the mode itself is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_RX;
            kind_q <= K_ACK_CONT;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            case (state_q)
                ST_RX:
                begin
                    if (acc_baud || acc_cont)
                    begin
                        kind_q <= acc_baud ? K_ACK_BAUD : K_ACK_CONT;
                        state_q <= ST_SEND;
                    end
                    else if (go_read)
                    begin
                        kind_q <= K_DATA;
                        start_q <= 1'b1;
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (last_fire)
                        state_q <= ST_RX;
                end
                default: state_q <= ST_RX;
            endcase
        end
    end

    assign tag_rd_start = start_q;
    assign tag_rd_addr = addr_q;
    assign tag_rd_len = len_q;

    // ------------------------------------------------------------
    // response bytes
    // ------------------------------------------------------------
    assign n2 = {1'b0, len_q, 1'b0};
    always_comb
    begin
        nb = TERM_WORD;
        nb_last = 1'b0;
        nb_tag = 1'b0;
        if (kind_q == K_DATA && compact)
        begin
            if (seq_q < 18'd2)
                nb = HDR_CMP;
            else if (seq_q == 18'd2)
                nb = 8'(({2'b00, len_q} + 18'd1) >> 8);
            else if (seq_q == 18'd3)
                nb = 8'({2'b00, len_q} + 18'd1);
            else if (seq_q == 18'd4)
                nb = CMD_CONT;
            else if (seq_q < 18'd5 + {2'b00, len_q})
            begin
                nb = tag_rd_data;
                nb_tag = 1'b1;
            end
            else if (seq_q == 18'd5 + {2'b00, len_q})
                nb = cksum_q;
            else
            begin
                nb = TERM_CMP;
                nb_last = 1'b1;
            end
        end
        else if (compact)
        begin
            case (seq_q[2:0])
                3'd0, 3'd1: nb = HDR_CMP;
                3'd2: nb = ACK_SIZE[15:8];
                3'd3: nb = ACK_SIZE[7:0];
                3'd4: nb = CMD_CONT;
                3'd5: nb = cksum_q;
                default:
                begin
                    nb = TERM_CMP;
                    nb_last = 1'b1;
                end
            endcase
        end
        else if (seq_q == 18'd0)
            nb = (kind_q == K_ACK_BAUD) ? HDR_BAUD : HDR_WORD;
        else if (seq_q == 18'd1)
            nb = (kind_q == K_ACK_BAUD) ? CMD_BAUD : CMD_CONT;
        else if (kind_q == K_DATA && seq_q < 18'd2 + n2)
        begin
            nb = seq_q[0] ? tag_rd_data : PAD_WORD;
            nb_tag = seq_q[0];
        end
        else
        begin
            nb = TERM_WORD;
            nb_last = (kind_q == K_DATA) ? (seq_q == 18'd3 + n2) : (seq_q == 18'd3);
        end
    end

    assign load = (state_q == ST_SEND) && !start_q && (!tx_valid_q || tx_ready) && (!nb_tag || tag_rd_valid);
    assign last_fire = load && nb_last;
    assign tag_rd_ready = load && nb_tag;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_q <= 18'd0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
        end
        else
        begin
            if (tx_valid_q && tx_ready)
                tx_valid_q <= 1'b0;
            if (load)
            begin
                tx_valid_q <= 1'b1;
                tx_data_q <= nb;
                seq_q <= nb_last ? 18'd0 : seq_q + 18'd1;
            end
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;

    // ------------------------------------------------------------
    // serial rate
    // ------------------------------------------------------------
    // switches when the last ack byte is handed over; the uart must finish it at the old rate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rate_q <= RATE_RESET;
        else if (last_fire && kind_q == K_ACK_BAUD)
            rate_q <= sh_q[15:0];
    end

    assign bif.div = rate_div(rate_q);
    assign baud_div = bif.div;
    assign baud_tick = bif.tick;
    assign cont_active = cont_q;

    crb_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .bif(bif)
    );

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
            cksum_q <= CKSUM_RESET;
        end
        else if (psel && penable && pwrite && paddr == OFF_CTRL)
            ctrl_q <= pwdata[1:0];
        else if (psel && penable && pwrite && paddr == OFF_CKSUM)
            cksum_q <= pwdata[7:0];
    end

    // read data captured in the setup phase so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            case (paddr)
                OFF_CTRL: prdata_q <= {30'h0000_0000, ctrl_q};
                OFF_STATUS: prdata_q <= {rate_q, 13'h0000, state_q != ST_RX, armed_q, cont_q};
                OFF_CFG: prdata_q <= {len_q, addr_q};
                OFF_DELAY: prdata_q <= {16'h0000, dly_q};
                OFF_CKSUM: prdata_q <= {24'h00_0000, cksum_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr != OFF_CTRL && paddr != OFF_STATUS && paddr != OFF_CFG
        && paddr != OFF_DELAY && paddr != OFF_CKSUM;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_STOP_CLEARS: assert property (acc_cont && f_len == 16'h0000 |=> !cont_q)
        else $error("zero length did not stop continuous reading");
    AST_START_SETS: assert property (acc_cont && f_len != 16'h0000 |=> cont_q && armed_q)
        else $error("nonzero length did not start continuous reading");
    AST_READ_ONLY_ARMED: assert property ($rose(start_q) |-> $past(cont_q) && $past(armed_q))
        else $error("tag read started while not armed");
    AST_DELAY_LIMIT: assert property (dly_q <= DELAY_MAX_S)
        else $error("delay above sixty seconds held");
    AST_RATE_LEGAL: assert property (rate_div(rate_q) != 16'h0000)
        else $error("illegal rate code held");
    AST_RATE_CAUSE: assert property ($changed(rate_q) |-> $past(last_fire) && $past(kind_q) == K_ACK_BAUD)
        else $error("rate changed without a baud ack");
    AST_WORD_PAD: assert property (load && !compact && kind_q == K_DATA && seq_q >= 18'd2 && seq_q < 18'd2 + n2
        && !seq_q[0] |=> tx_data == PAD_WORD)
        else $error("word data upper byte not zero");
    AST_STOP_SHORT: assert property (load && !compact && kind_q != K_DATA |-> seq_q < 18'd4)
        else $error("word ack longer than four bytes");
    AST_CMP_ACK_SIZE: assert property (load && compact && kind_q != K_DATA && seq_q == 18'd3
        |=> tx_data == ACK_SIZE[7:0])
        else $error("compact ack size not one");
    AST_REARM_WAIT: assert property ($rose(armed_q) && !$past(acc_cont) && $past(dly_q) != 16'h0000
        |-> $past(abs_s_q) >= $past(dly_q))
        else $error("re-armed before the delay ran out");
endmodule : crb_cmd
`default_nettype wire

// [crb_tag_model.sv]
// tag read engine model feeding tag bytes to the interpreter
`default_nettype none
module crb_tag_model
(
    input wire logic pclk,
    input wire logic tag_rd_start,
    input wire logic [15:0] tag_rd_addr,
    input wire logic [15:0] tag_rd_len,
    input wire logic tag_rd_ready,
    output logic tag_rd_valid,
    output logic [7:0] tag_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_q = 16'h0000;
    logic [15:0] pos_q = 16'h0000;
    assign tag_rd_valid = (left_q != 16'h0000);
    // idle data is scrambled so a stale byte can never pass for a good one
    assign tag_rd_data = tag_rd_valid ? 8'h50 + pos_q[7:0] : ~pos_q[7:0];
    always @(posedge pclk)
    begin
        if (tag_rd_start)
        begin
            left_q <= tag_rd_len;
            pos_q <= tag_rd_addr;
        end
        else if (tag_rd_valid && tag_rd_ready)
        begin
            left_q <= left_q - 16'h0001;
            pos_q <= pos_q + 16'h0001;
        end
    end
endmodule : crb_tag_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the command interpreter
`default_nettype none
module tb;
    import crb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] crb_bytes_t [$];
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic pready, pslverr, slv, rx_valid = 1'b0, rx_ready, tx_valid, tx_ready = 1'b1, baud_tick;
    logic [7:0] rx_data = 8'h00, tx_data, tag_rd_data;
    logic [15:0] baud_div, tag_rd_addr, tag_rd_len;
    logic tag_present = 1'b0, tag_rd_start, tag_rd_valid, tag_rd_ready, cont_active;
    logic [15:0] codes [7] = '{RATE_1200, RATE_4800, RATE_9600, RATE_19200, RATE_38400, RATE_57600, RATE_115200};
    int rates [7] = '{1200, 4800, 9600, 19200, 38400, 57600, 115200};
    int failures = 0, samples_checked = 0, cyc = 0, starts = 0, nticks = 0;
    crb_bytes_t cdat = '{8'h02, 8'h02, 8'h00, 8'h09, 8'h0D, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
        8'hE1, 8'h03};
    // short second so duplicate-suppression timing stays cheap to simulate
    crb_cmd #(.SEC_CYC(20)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .baud_tick(baud_tick), .baud_div(baud_div), .tag_present(tag_present),
        .tag_rd_start(tag_rd_start), .tag_rd_addr(tag_rd_addr), .tag_rd_len(tag_rd_len),
        .tag_rd_valid(tag_rd_valid), .tag_rd_data(tag_rd_data), .tag_rd_ready(tag_rd_ready),
        .cont_active(cont_active));
    crb_tag_model partner (.pclk(pclk), .tag_rd_start(tag_rd_start), .tag_rd_addr(tag_rd_addr),
        .tag_rd_len(tag_rd_len), .tag_rd_ready(tag_rd_ready), .tag_rd_valid(tag_rd_valid),
        .tag_rd_data(tag_rd_data));
    always #20 pclk = ~pclk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // host side: one frame at a time, never overlapping a pending answer
    task automatic send(input crb_bytes_t f);
        foreach (f[i])
        begin
            rx_valid <= 1'b1;
            rx_data <= f[i];
            do @(posedge pclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
    endtask : send
    task automatic expect_bytes(input crb_bytes_t f);
        foreach (f[i])
        begin
            do @(negedge pclk); while (tx_valid !== 1'b1);
            chk(32'(tx_data), 32'(f[i]));
            @(posedge pclk);
        end
    endtask : expect_bytes
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (tag_rd_start === 1'b1)
            starts++;
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(baud_div), 32'(CLK_HZ / 9600));
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(rdv, {RATE_9600, 16'h0000});
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(32'(slv), 32'h0000_0001);
        chk(rdv, 32'h0000_0000);
        $display("reset test done");
        send('{8'hAA, 8'h0D, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'hFF, 8'hFF});
        expect_bytes('{8'hAA, 8'h0D, 8'hFF, 8'hFF});
        chk(32'(cont_active), 32'h0000_0001);
        tag_present <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            do @(posedge pclk); while (tag_rd_start !== 1'b1);
            tag_present <= (k == 0);
            chk({tag_rd_len, tag_rd_addr}, 32'h0002_0001);
            expect_bytes('{8'hAA, 8'h0D, 8'h00, 8'h51, 8'h00, 8'h52, 8'hFF, 8'hFF});
        end
        send('{8'h00, 8'h0A, 8'h00, 8'h60, 8'hFF, 8'hFF});
        expect_bytes('{8'h00, 8'h0A, 8'hFF, 8'hFF});
        chk(32'(cont_active), 32'h0000_0001);
        send('{8'hAA, 8'h0D, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF});
        expect_bytes('{8'hAA, 8'h0D, 8'hFF, 8'hFF});
        chk(32'(cont_active), 32'h0000_0000);
        tag_present <= 1'b1;
        repeat (30) @(posedge pclk);
        chk(32'(tx_valid), 32'h0000_0000);
        chk(starts, 32'h0000_0002);
        tag_present <= 1'b0;
        $display("word framing test done");
        foreach (codes[i])
        begin
            send('{8'h00, 8'h0A, codes[i][15:8], codes[i][7:0], 8'hFF, 8'hFF});
            expect_bytes('{8'h00, 8'h0A, 8'hFF, 8'hFF});
            chk(32'(baud_div), 32'(CLK_HZ / rates[i]));
        end
        do @(posedge pclk); while (baud_tick !== 1'b1);
        nticks = 0;
        do
        begin
            @(posedge pclk);
            nticks++;
        end
        while (baud_tick !== 1'b1);
        chk(nticks, 32'(CLK_HZ / 115200));
        $display("rate test done");
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        apb(1'b1, OFF_CKSUM, 32'h0000_00E1);
        send('{8'h02, 8'h02, 8'h00, 8'h06, 8'h0D, 8'h00, 8'h01, 8'h00, 8'h08, 8'h02, 8'hE1, 8'h03});
        expect_bytes('{8'h02, 8'h02, 8'h00, 8'h01, 8'h0D, 8'hE1, 8'h03});
        chk(32'(cont_active), 32'h0000_0001);
        apb(1'b0, OFF_CFG, 32'h0000_0000);
        chk(rdv, 32'h0008_0001);
        apb(1'b0, OFF_DELAY, 32'h0000_0000);
        chk(rdv, 32'h0000_0002);
        tag_present <= 1'b1;
        do @(posedge pclk); while (tag_rd_start !== 1'b1);
        expect_bytes(cdat);
        repeat (60) @(posedge pclk);
        tag_present <= 1'b0;
        repeat (30) @(posedge pclk);
        tag_present <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(starts, 32'h0000_0003);
        tag_present <= 1'b0;
        repeat (50) @(posedge pclk);
        tag_present <= 1'b1;
        do @(posedge pclk); while (tag_rd_start !== 1'b1);
        expect_bytes(cdat);
        chk(starts, 32'h0000_0004);
        $display("compact framing test done");
        conclude();
    end
endmodule : tb
`default_nettype wire
